/* core/tpg_gpio_bank.sv */
module tpg_gpio_bank (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RESET,
  input  wire logic                  CE,
  input  wire tpg_pkg::tpg_bus_req_t BUS_REQ,
  output logic      [7:0]            RDATA,
  input  wire logic [7:0]            P4_IN,
  output tpg_pkg::tpg_pin_drive_t    P4_DRV,
  input  wire logic [7:0]            P5_IN,
  output tpg_pkg::tpg_pin_drive_t    P5_DRV,
  input  wire logic [7:0]            P6_IN,
  output tpg_pkg::tpg_pin_drive_t    P6_DRV,
  output tpg_pkg::tpg_analog_t       P6_ANALOG
);
  import tpg_pkg::*;

  logic [7:0] p4_latch_r;
  logic [7:0] p4_dir_r;
  logic [7:0] p4_drain_r;
  logic [7:0] p5_latch_r;
  logic [7:0] p5_dir_r;
  logic [7:0] p6_latch_r;
  logic [7:0] p6_dir_r;
  logic [7:0] p6_pu_r;
  logic       an_dis_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] p4_pin;
  logic [7:0] p5_pin;
  logic [7:0] p6_pin;
  logic [7:0] p6_oe_n;
  logic [7:0] p6_fixed_zero;
  logic [7:0] p6_analog;
  logic [7:0] p6_pullup;
  logic [7:0] p5_view;
  logic [7:0] p6_view;
  logic       wr;
  logic       rd;

  assign wr = BUS_REQ.wr & CE;
  assign rd = BUS_REQ.rd & CE;

  tpg_sync u_sync_p4 (
    .clk (SYS_CLK),
    .rst (RESET),
    .ce  (CE),
    .d   (P4_IN),
    .q   (p4_pin)
  );

  tpg_sync u_sync_p5 (
    .clk (SYS_CLK),
    .rst (RESET),
    .ce  (CE),
    .d   (P5_IN),
    .q   (p5_pin)
  );

  tpg_sync u_sync_p6 (
    .clk (SYS_CLK),
    .rst (RESET),
    .ce  (CE),
    .d   (P6_IN),
    .q   (p6_pin)
  );

  tpg_p6_mode u_p6_mode (
    .dir        (p6_dir_r),
    .latch      (p6_latch_r),
    .pu_en      (p6_pu_r),
    .an_dis     (an_dis_r),
    .oe_n       (p6_oe_n),
    .fixed_zero (p6_fixed_zero),
    .analog     (p6_analog),
    .pull_on    (p6_pullup)
  );

  // port4 registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      p4_dir_r <= RST_P4_DIR;
    end else if (wr && BUS_REQ.addr == ADDR_P4_DIR) begin
      p4_dir_r <= BUS_REQ.wdata;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      p4_latch_r <= RST_P4_LATCH;
    end else if (wr && BUS_REQ.addr == ADDR_P4_LATCH) begin
      p4_latch_r <= BUS_REQ.wdata;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      p4_drain_r <= RST_P4_DRAIN;
    end else if (wr && BUS_REQ.addr == ADDR_P4_DRAIN) begin
      p4_drain_r <= BUS_REQ.wdata;
    end
  end

  // port5 registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      p5_dir_r   <= RST_P5_DIR;
      p5_latch_r <= RST_P5_LATCH;
    end else if (wr) begin
      if (BUS_REQ.addr == ADDR_P5_DIR) begin
        p5_dir_r <= BUS_REQ.wdata;
      end
      if (BUS_REQ.addr == ADDR_P5_LATCH) begin
        p5_latch_r <= BUS_REQ.wdata;
      end
    end
  end

  // port6 registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      p6_dir_r   <= RST_P6_DIR;
      p6_latch_r <= RST_P6_LATCH;
      an_dis_r   <= RST_ANALOG_DIS;
    end else if (wr) begin
      if (BUS_REQ.addr == ADDR_P6_DIR) begin
        p6_dir_r <= BUS_REQ.wdata;
      end
      if (BUS_REQ.addr == ADDR_P6_LATCH) begin
        p6_latch_r <= BUS_REQ.wdata;
      end
      if (BUS_REQ.addr == ADDR_ANALOG_CTRL) begin
        an_dis_r <= BUS_REQ.wdata[ANALOG_DIS_BIT];
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      p6_pu_r <= RST_P6_PULLUP;
    end else if (wr && BUS_REQ.addr == ADDR_P6_PULLUP) begin
      p6_pu_r <= BUS_REQ.wdata;
    end
  end

  // data views seen by software
  for (genvar i = 0; i < DATA_W; i++) begin : g_view
    assign p5_view[i] = p5_dir_r[i] ? p5_latch_r[i] : p5_pin[i];
    assign p6_view[i] = p6_dir_r[i] ? p6_latch_r[i] :
                        ((p6_fixed_zero[i] | p6_analog[i]) ? 1'b0 : p6_pin[i]);
  end

  // read mux
  always_comb begin
    case (BUS_REQ.addr)
      ADDR_P4_LATCH:    rdata_nxt = p4_latch_r;
      ADDR_P4_PIN:      rdata_nxt = p4_pin;
      ADDR_P4_DIR:      rdata_nxt = p4_dir_r;
      ADDR_P4_DRAIN:    rdata_nxt = p4_drain_r;
      ADDR_P5_LATCH:    rdata_nxt = p5_view;
      ADDR_P5_DIR:      rdata_nxt = p5_dir_r;
      ADDR_P6_LATCH:    rdata_nxt = p6_view;
      ADDR_P6_DIR:      rdata_nxt = p6_dir_r;
      ADDR_P6_PULLUP:   rdata_nxt = p6_pu_r;
      ADDR_ANALOG_CTRL: rdata_nxt = {7'h00, an_dis_r};
      default:          rdata_nxt = ZERO_BYTE;
    endcase
  end

  // read data held after the strobe until the next edge with CE high, then zero
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_r <= ZERO_BYTE;
    end else if (CE) begin
      rdata_r <= rd ? rdata_nxt : ZERO_BYTE;
    end
  end

  assign RDATA = rdata_r;

  // port4 pin drive
  for (genvar i = 0; i < DATA_W; i++) begin : g_p4
    assign P4_DRV.out[i]  = p4_drain_r[i] ? 1'b0 : p4_latch_r[i];
    assign P4_DRV.oe_n[i] = ~p4_dir_r[i] | (p4_drain_r[i] & p4_latch_r[i]);
  end

  assign P5_DRV.out  = p5_latch_r;
  assign P5_DRV.oe_n = ~p5_dir_r;

  assign P6_DRV.out  = p6_latch_r;
  assign P6_DRV.oe_n = p6_oe_n;

  assign P6_ANALOG.analog_sel           = p6_analog;
  assign P6_ANALOG.pullup_on            = p6_pullup;
  assign P6_ANALOG.analog_input_disable = an_dis_r;
endmodule : tpg_gpio_bank

/* core/tpg_pkg.sv */
package tpg_pkg;
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 8;
  localparam logic [11:0] ADDR_P4_LATCH     = 12'h004;
  localparam logic [11:0] ADDR_P6_LATCH     = 12'h006;
  localparam logic [11:0] ADDR_P4_PIN       = 12'h00A;
  localparam logic [11:0] ADDR_P4_DIR       = 12'h00C;
  localparam logic [11:0] ADDR_P4_DRAIN     = 12'h02D;
  localparam logic [11:0] ADDR_P6_DIR       = 12'h02E;
  localparam logic [11:0] ADDR_P6_PULLUP    = 12'hFBC;
  localparam logic [11:0] ADDR_P5_LATCH     = 12'h010;
  localparam logic [11:0] ADDR_P5_DIR       = 12'h011;
  localparam logic [11:0] ADDR_ANALOG_CTRL  = 12'h012;
  localparam int          ANALOG_DIS_BIT    = 0;
  localparam logic [7:0]  RST_P4_LATCH      = 8'hFF;
  localparam logic [7:0]  RST_P4_DIR        = 8'h00;
  localparam logic [7:0]  RST_P4_DRAIN      = 8'h00;
  localparam logic [7:0]  RST_P5_LATCH      = 8'h00;
  localparam logic [7:0]  RST_P5_DIR        = 8'h00;
  localparam logic [7:0]  RST_P6_LATCH      = 8'h00;
  localparam logic [7:0]  RST_P6_DIR        = 8'h00;
  localparam logic [7:0]  RST_P6_PULLUP     = 8'h00;
  localparam logic        RST_ANALOG_DIS    = 1'b1;
  localparam logic [7:0]  ZERO_BYTE         = 8'h00;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } tpg_bus_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } tpg_pin_drive_t;

  typedef struct packed {
    logic [7:0] analog_sel;
    logic [7:0] pullup_on;
    logic       analog_input_disable;
  } tpg_analog_t;
endpackage : tpg_pkg

/* core/tpg_sync.sv */
module tpg_sync (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] d,
  output logic      [7:0] q
);
  import tpg_pkg::*;
  logic [7:0] meta_r;

  // two flops per bit
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_r[i] <= 1'b0;
        q[i]      <= 1'b0;
      end else if (ce) begin
        meta_r[i] <= d[i];
        q[i]      <= meta_r[i];
      end
    end
  end
endmodule : tpg_sync

/* core/tpg_p6_mode.sv */
module tpg_p6_mode (
  input  wire logic [7:0] dir,
  input  wire logic [7:0] latch,
  input  wire logic [7:0] pu_en,
  input  wire logic       an_dis,
  output logic      [7:0] oe_n,
  output logic      [7:0] fixed_zero,
  output logic      [7:0] analog,
  output logic      [7:0] pull_on
);
  import tpg_pkg::*;

  // per-bit mode matrix
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    assign oe_n[i]       = ~dir[i];
    assign fixed_zero[i] = ~dir[i] & ~latch[i] & an_dis;
    assign analog[i]     = ~dir[i] & ~latch[i] & ~an_dis;
    assign pull_on[i]    = pu_en[i] & ~dir[i];
  end
endmodule : tpg_p6_mode

/* testbench/tpg_gpio_bank_sva.sv */
module tpg_gpio_bank_sva (
  input wire logic                    SYS_CLK,
  input wire logic                    RESET,
  input wire logic                    CE,
  input wire tpg_pkg::tpg_bus_req_t   BUS_REQ,
  input wire logic [7:0]              RDATA,
  input wire logic [7:0]              P4_IN,
  input wire tpg_pkg::tpg_pin_drive_t P4_DRV,
  input wire tpg_pkg::tpg_pin_drive_t P5_DRV,
  input wire tpg_pkg::tpg_pin_drive_t P6_DRV,
  input wire tpg_pkg::tpg_analog_t    P6_ANALOG
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpg_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic        wr;
  logic        rd;
  logic [11:0] a;
  assign wr = CE && BUS_REQ.wr;
  assign rd = CE && BUS_REQ.rd;
  assign a  = BUS_REQ.addr;
  // pins quiet long enough to pass the sync flops
  sequence s_pin_rd;
    $stable(P4_IN) [*4] ##0 (rd && a == ADDR_P4_PIN);
  endsequence
  AST_P4_DIR: assert property (wr && a == ADDR_P4_DIR |=>
    (P4_DRV.oe_n | $past(BUS_REQ.wdata)) == 8'hFF) else $error("p4 input bit driven");
  AST_P4_OUT: assert property (wr && a == ADDR_P4_LATCH |=>
    ((P4_DRV.out ^ $past(BUS_REQ.wdata)) & ~P4_DRV.oe_n) == 8'h00) else $error("p4 out");
  AST_P4_PIN_RO: assert property (wr && a == ADDR_P4_PIN |=> $stable(P4_DRV))
    else $error("p4 pin register written");
  AST_P4_PIN_RD: assert property (s_pin_rd |=> RDATA == $past(P4_IN))
    else $error("p4 pin read");
  AST_P5_DIR: assert property (wr && a == ADDR_P5_DIR |=>
    P5_DRV.oe_n == ~$past(BUS_REQ.wdata)) else $error("p5 dir");
  AST_P6_PULL: assert property ((P6_ANALOG.pullup_on & ~P6_DRV.oe_n) == 8'h00)
    else $error("p6 pull-up on output");
  AST_P6_AN: assert property ((P6_ANALOG.analog_sel &
    (~P6_DRV.oe_n | {8{P6_ANALOG.analog_input_disable}})) == 8'h00) else $error("p6 mode");
  AST_P6_RD0: assert property (rd && a == ADDR_P6_LATCH |=>
    (RDATA & $past(P6_ANALOG.analog_sel)) == 8'h00) else $error("p6 analog read");
endmodule : tpg_gpio_bank_sva

bind tpg_gpio_bank tpg_gpio_bank_sva i_sva (.SYS_CLK(SYS_CLK), .RESET(RESET), .CE(CE),
  .BUS_REQ(BUS_REQ), .RDATA(RDATA), .P4_IN(P4_IN), .P4_DRV(P4_DRV), .P5_DRV(P5_DRV),
  .P6_DRV(P6_DRV), .P6_ANALOG(P6_ANALOG));

/* testbench/tpg_pin_board.sv */
module tpg_pin_board (
  input  wire tpg_pkg::tpg_pin_drive_t drv,
  input  wire logic [7:0]              ext,
  output logic      [7:0]              pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpg_pkg::*;
  // driven bits follow the port, released bits take the board level
  assign pin = (drv.out & ~drv.oe_n) | (ext & drv.oe_n);
endmodule : tpg_pin_board

/* testbench/test_three_port_gpio_bank.sv */
module test_three_port_gpio_bank;
  timeunit 1ns;
  timeprecision 1ps;
  import tpg_pkg::*;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
  localparam logic [11:0] RA [9] = '{ADDR_P4_LATCH, ADDR_P4_DIR, ADDR_P4_DRAIN, ADDR_P5_DIR,
    ADDR_P6_DIR, ADDR_P6_PULLUP, ADDR_P6_LATCH, ADDR_ANALOG_CTRL, 12'h005};
  localparam logic [7:0]  RV [9] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h00};
  logic           clk;
  logic           rst;
  logic           ce;
  tpg_bus_req_t   req;
  logic [7:0]     rdata;
  logic [7:0]     p4, p5, p6;
  tpg_pin_drive_t d4, d5, d6;
  tpg_analog_t    an;
  int             num_errors = 0;
  int             compares = 0;
  tpg_gpio_bank i_tpg_gpio_bank (.SYS_CLK(clk), .RESET(rst), .CE(ce), .BUS_REQ(req),
    .RDATA(rdata), .P4_IN(p4), .P4_DRV(d4), .P5_IN(p5), .P5_DRV(d5), .P6_IN(p6),
    .P6_DRV(d6), .P6_ANALOG(an));
  tpg_pin_board b4 (.drv(d4), .ext(8'hA5), .pin(p4));
  tpg_pin_board b5 (.drv(d5), .ext(8'hAA), .pin(p5));
  tpg_pin_board b6 (.drv(d6), .ext(8'hFF), .pin(p6));
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr    <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd   <= 1'b0;
    @(posedge clk);
    `CHK(rdata, e)
  endtask : rd
  task automatic close_out;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (1000) @(posedge clk);
    num_errors++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    ce  = 1'b1;
    req = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(d4.oe_n, 8'hFF)
    foreach (RA[i]) rd(RA[i], RV[i]);
    // receive and interrupt pins in, transmit and clock out
    wr(ADDR_P4_DIR, 8'h25);
    wr(ADDR_P4_DRAIN, 8'h01);
    wr(ADDR_P4_LATCH, 8'h5B);
    `CHK(d4.oe_n, 8'hDB)
    repeat (4) @(posedge clk);
    rd(ADDR_P4_PIN, 8'h81);
    rd(ADDR_P4_LATCH, 8'h5B);
    wr(ADDR_P4_LATCH, 8'hDB);
    wr(ADDR_P4_PIN, 8'h00);
    rd(ADDR_P4_LATCH, 8'hDB);
    wr(ADDR_P4_LATCH, 8'hDA);
    `CHK(d4.oe_n, 8'hDA)
    `CHK(d4.out, 8'hDA)
    ce <= 1'b0;
    wr(ADDR_P4_DRAIN, 8'hFF);
    ce <= 1'b1;
    rd(ADDR_P4_DRAIN, 8'h01);
    wr(ADDR_P5_DIR, 8'h0F);
    wr(ADDR_P5_LATCH, 8'hF0);
    repeat (2) @(posedge clk);
    rd(ADDR_P5_LATCH, 8'hA0);
    `CHK(d5.oe_n, 8'hF0)
    `CHK(d5.out, 8'hF0)
    wr(ADDR_P5_LATCH, 8'hA1);
    wr(ADDR_P5_DIR, 8'hFF);
    rd(ADDR_P5_LATCH, 8'hA1);
    wr(ADDR_P6_PULLUP, 8'hFF);
    wr(ADDR_P6_LATCH, 8'hF1);
    wr(ADDR_P6_DIR, 8'h03);
    wr(ADDR_ANALOG_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    rd(ADDR_P6_LATCH, 8'hF1);
    `CHK(an.analog_sel, 8'h0C)
    `CHK(an.pullup_on, 8'hFC)
    `CHK(d6.out, 8'hF1)
    `CHK(d6.oe_n, 8'hFC)
    wr(ADDR_ANALOG_CTRL, 8'h01);
    wr(ADDR_P6_DIR, 8'h00);
    repeat (2) @(posedge clk);
    rd(ADDR_P6_LATCH, 8'hF1);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_P4_LATCH, 8'hFF);
    close_out;
  end
endmodule : test_three_port_gpio_bank
